// ==== rtl/sdram_init_pkg.sv ====
// constants, command codes and states for the synchronous dram power-up and mode-set controller
// assumes a 200 MHz system clock that is also forwarded as the dram command clock
package sdram_init_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned PS_PER_NS = 1000;
    localparam int unsigned PS_PER_US = 1000000;
    // printed times
    localparam int unsigned T_RESET_HOLD_US = 200;
    localparam int unsigned T_CKE_LOW_US = 500;
    localparam int unsigned T_CKE_SETUP_NS = 10;
    localparam int unsigned MIN_CLK_BEFORE_CKE = 5;
    localparam int unsigned T_DLLK_CK = 512;
    // part-dependent times, plain defaults
    localparam int unsigned T_XPR_NS = 170;
    localparam int unsigned T_MOD_NS = 60;
    localparam int unsigned T_XPDLL_NS = 24;
    localparam int unsigned T_MRD_CK = 4;
    localparam int unsigned T_ZQINIT_CK = 512;

    function automatic int unsigned cyc_up(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c == 0) ? 1 : c;
    endfunction : cyc_up

    localparam int unsigned RESET_HOLD_CYC = cyc_up(T_RESET_HOLD_US * PS_PER_US);
    localparam int unsigned CKE_LOW_CYC = cyc_up(T_CKE_LOW_US * PS_PER_US) - 1;
    localparam int unsigned CKE_SETUP_CYC = cyc_up(T_CKE_SETUP_NS * PS_PER_NS);
    localparam int unsigned XPR_CYC = cyc_up(T_XPR_NS * PS_PER_NS);
    localparam int unsigned MRD_CYC = T_MRD_CK;
    localparam int unsigned MOD_RAW = cyc_up(T_MOD_NS * PS_PER_NS);
    localparam int unsigned MOD_CYC = (MOD_RAW > MRD_CYC) ? MOD_RAW : MRD_CYC;
    localparam int unsigned XPDLL_RAW = cyc_up(T_XPDLL_NS * PS_PER_NS);
    localparam int unsigned CL_GAP_CYC = (XPDLL_RAW > MOD_CYC) ? XPDLL_RAW : MOD_CYC;
    localparam int unsigned DLLK_CYC = T_DLLK_CK;
    localparam int unsigned ZQINIT_CYC = T_ZQINIT_CK;

    localparam int unsigned CNT_W = 17;
    localparam int unsigned MODE_W = 17;
    localparam logic [MODE_W-1:0] MR0_RSVD_MASK = 17'h1_2084;
    localparam int unsigned MR0_DLL_RESET_BIT = 8;
    localparam int unsigned MR1_DLL_OFF_BIT = 0;
    localparam int unsigned ZQ_LONG_BIT = 10;
    localparam logic [MODE_W-1:0] MR_RESET = 17'h0_0000;

    // register map, byte offsets
    localparam int unsigned OFF_W = 8;
    localparam logic [OFF_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [OFF_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [OFF_W-1:0] OFF_MR0 = 8'h08;
    localparam logic [OFF_W-1:0] OFF_MRS_REQ = 8'h18;
    localparam int unsigned OFF_STEP = 4;
    localparam int unsigned CTRL_REINIT = 0;
    localparam int unsigned CTRL_ODT_ALLOW = 1;
    localparam int unsigned CTRL_CL_CHANGE = 2;
    localparam int unsigned ST_DONE_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 1;
    localparam int unsigned ST_PEND_BIT = 2;
    localparam int unsigned ST_STATE_LSB = 4;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } ddr_cmd_s;
    localparam ddr_cmd_s CMD_NOP = 4'h7;
    localparam ddr_cmd_s CMD_DES = 4'hf;
    localparam ddr_cmd_s CMD_MRS = 4'h0;
    localparam ddr_cmd_s CMD_ZQ = 4'h6;

    typedef enum logic [3:0] {
        ST_HOLD, ST_CKE_WAIT, ST_XPR, ST_MRS, ST_MRS_GAP, ST_ZQ, ST_ZQ_WAIT, ST_READY, ST_RT_GAP
    } init_state_e;

    // programming order: register two, three, one, then base
    function automatic logic [1:0] init_target(input logic [1:0] step);
        case (step)
            2'h0: return 2'h2;
            2'h1: return 2'h3;
            2'h2: return 2'h1;
            default: return 2'h0;
        endcase
    endfunction : init_target
endpackage : sdram_init_pkg

// ==== rtl/sdram_init_mode_program.sv ====
// host-side sequencer: dram power-up, mode register programming, long calibration, run-time mode sets
// assumes sys_clk is also the dram clock and an ahb-lite master owns the control registers
//
// Summary of operation
// - hold power_on_clear_n low at least 200 us after power is stable.
// - clock_gate_enable low at least 10 ns before power_on_clear_n rises.
// - keep clock_gate_enable low 500 us minus one clock after reset release.
// - clock runs at least 10 ns and five cycles before clock_gate_enable high.
// - termination_enable low at least input setup time before clock_gate_enable rises.
// - after clock_gate_enable rises: only idle or deselect, enable kept high.
// - after exit-reset delay program mode registers two, three, one, base.
// - mode register two is addressed with bank bits 0,1,0.
// - init write to register one enables the dll and sets termination.
// - init write to base register requests dll reset; lock takes 512 cycles.
// - then long calibration; wait calibration delay and dll lock before ready.
// - each mode set supplies every field of its register.
// - mode set only with all banks idle, precharged, no burst.
// - consecutive mode sets spaced at least the mode-set cycle time.
// - after a mode set only idle commands until mode-update delay.
// - clock_gate_enable high from mode set until power-down delay passes.
// - cas latency change waits dll-off power-down exit before other commands.
// - termination_enable held low from mode set until mode-update delay.
// - base register bits 16, 13, 7 and 2 written as zero.
`timescale 1ns/1ps
module sdram_init_mode_program #(
    parameter int unsigned RESET_HOLD_CYC = sdram_init_pkg::RESET_HOLD_CYC,
    parameter int unsigned CKE_LOW_CYC = sdram_init_pkg::CKE_LOW_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic banks_idle,
    output logic power_on_clear_n,
    output logic clock_gate_enable,
    output logic termination_enable,
    output sdram_init_pkg::ddr_cmd_s ddr_cmd,
    output logic [2:0] bank_select_bits,
    output logic [sdram_init_pkg::MODE_W-1:0] mode_addr
);
    localparam int unsigned CW = sdram_init_pkg::CNT_W;
    localparam int unsigned MW = sdram_init_pkg::MODE_W;

    // bus slave: zero-wait writes, one wait state on reads so hrdata comes from a flop
    logic wr_ff, rd_ff;
    logic [sdram_init_pkg::OFF_W-1:0] addr_ff;
    logic [31:0] hrdata_ff;
    wire take = hsel && htrans[1] && hready;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= '0;
        end else begin
            wr_ff <= take && hwrite;
            rd_ff <= take && !hwrite;
            if (take) begin
                addr_ff <= haddr[sdram_init_pkg::OFF_W-1:0];
            end
        end
    end
    assign hreadyout = !rd_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    wire wr_ctrl = wr_ff && (addr_ff == sdram_init_pkg::OFF_CTRL);
    wire wr_req = wr_ff && (addr_ff == sdram_init_pkg::OFF_MRS_REQ);

    // software shadows of the four mode registers, sent whole on every mode set
    logic [MW-1:0] mr_ff [4];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mr
            wire hit = wr_ff && (addr_ff == 8'(sdram_init_pkg::OFF_MR0 + gi * sdram_init_pkg::OFF_STEP));
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    mr_ff[gi] <= sdram_init_pkg::MR_RESET;
                end else if (hit) begin
                    mr_ff[gi] <= hwdata[MW-1:0];
                end
            end
        end
    endgenerate

    logic odt_allow_ff, cl_change_ff, rt_pend_ff, init_done_ff;
    logic [1:0] rt_sel_ff;
    sdram_init_pkg::init_state_e state_ff, nxt_state;
    wire rt_issue = (state_ff == sdram_init_pkg::ST_READY) && rt_pend_ff && banks_idle;
    wire reinit = wr_ctrl && hwdata[sdram_init_pkg::CTRL_REINIT];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            odt_allow_ff <= 1'b0;
            cl_change_ff <= 1'b0;
            rt_pend_ff <= 1'b0;
            rt_sel_ff <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                odt_allow_ff <= hwdata[sdram_init_pkg::CTRL_ODT_ALLOW];
                cl_change_ff <= hwdata[sdram_init_pkg::CTRL_CL_CHANGE];
            end
            // a new request written in the issue cycle wins over the clear
            if (wr_req) begin
                rt_pend_ff <= 1'b1;
                rt_sel_ff <= hwdata[1:0];
            end else if (rt_issue) begin
                rt_pend_ff <= 1'b0;
            end
        end
    end

    wire [3:0] state_code = state_ff;
    wire [31:0] status_word = {24'h00_0000, state_code, 1'b0, rt_pend_ff,
                               (state_ff != sdram_init_pkg::ST_READY), init_done_ff};
    wire [31:0] ctrl_word = {29'h0000_0000, cl_change_ff, odt_allow_ff, 1'b0};
    wire [2:0] rd_idx = 3'((addr_ff - sdram_init_pkg::OFF_MR0) >> 2);
    wire rd_mr = (addr_ff >= sdram_init_pkg::OFF_MR0) && (addr_ff < sdram_init_pkg::OFF_MRS_REQ)
                 && (addr_ff[1:0] == 2'h0);
    wire [31:0] rd_mux = (addr_ff == sdram_init_pkg::OFF_CTRL) ? ctrl_word :
                         (addr_ff == sdram_init_pkg::OFF_STATUS) ? status_word :
                         (addr_ff == sdram_init_pkg::OFF_MRS_REQ) ? {30'h0000_0000, rt_sel_ff} :
                         rd_mr ? {15'h0000, mr_ff[rd_idx[1:0]]} : 32'h0000_0000;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_ff) begin
            hrdata_ff <= rd_mux;
        end
    end

    // sequencer
    logic [CW-1:0] wait_ff, nxt_wait, dll_ff;
    logic [1:0] step_ff, nxt_step;
    logic pocn_ff, cke_ff, odt_ff;
    sdram_init_pkg::ddr_cmd_s cmd_ff, nxt_cmd;
    logic [2:0] bank_ff, nxt_bank;
    logic [MW-1:0] maddr_ff, nxt_maddr;
    wire wait_done = (wait_ff == '0);
    wire [1:0] init_tgt = sdram_init_pkg::init_target(step_ff);

    // full image of the target register; reserved base bits forced to zero
    function automatic logic [MW-1:0] mr_image(input logic [1:0] tgt, input logic initial_pass,
                                               input logic [MW-1:0] sw);
        logic [MW-1:0] v;
        v = sw;
        if (tgt == 2'h0) begin
            v = v & ~sdram_init_pkg::MR0_RSVD_MASK;
            if (initial_pass) begin
                v[sdram_init_pkg::MR0_DLL_RESET_BIT] = 1'b1;
            end
        end
        if (tgt == 2'h1 && initial_pass) begin
            v[sdram_init_pkg::MR1_DLL_OFF_BIT] = 1'b0;
        end
        return v;
    endfunction : mr_image

    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_done ? wait_ff : wait_ff - 1'b1;
        nxt_step = step_ff;
        nxt_cmd = sdram_init_pkg::CMD_NOP;
        nxt_bank = 3'h0;
        nxt_maddr = '0;
        case (state_ff)
            sdram_init_pkg::ST_HOLD: begin
                if (wait_done) begin
                    nxt_state = sdram_init_pkg::ST_CKE_WAIT;
                    nxt_wait = CW'(CKE_LOW_CYC - 1);
                end
            end
            sdram_init_pkg::ST_CKE_WAIT: begin
                if (wait_done) begin
                    nxt_state = sdram_init_pkg::ST_XPR;
                    nxt_wait = CW'(sdram_init_pkg::XPR_CYC - 1);
                end
            end
            sdram_init_pkg::ST_XPR: begin
                if (wait_done) begin
                    nxt_state = sdram_init_pkg::ST_MRS;
                    nxt_step = 2'h0;
                end
            end
            sdram_init_pkg::ST_MRS: begin
                nxt_cmd = sdram_init_pkg::CMD_MRS;
                nxt_bank = {1'b0, init_tgt};
                nxt_maddr = mr_image(init_tgt, 1'b1, mr_ff[init_tgt]);
                nxt_state = sdram_init_pkg::ST_MRS_GAP;
                nxt_wait = (step_ff == 2'h3) ? CW'(sdram_init_pkg::MOD_CYC - 1)
                                             : CW'(sdram_init_pkg::MRD_CYC - 1);
            end
            sdram_init_pkg::ST_MRS_GAP: begin
                if (wait_done) begin
                    nxt_step = step_ff + 2'h1;
                    nxt_state = (step_ff == 2'h3) ? sdram_init_pkg::ST_ZQ : sdram_init_pkg::ST_MRS;
                end
            end
            sdram_init_pkg::ST_ZQ: begin
                nxt_cmd = sdram_init_pkg::CMD_ZQ;
                nxt_maddr[sdram_init_pkg::ZQ_LONG_BIT] = 1'b1;
                nxt_state = sdram_init_pkg::ST_ZQ_WAIT;
                nxt_wait = CW'(sdram_init_pkg::ZQINIT_CYC - 1);
            end
            sdram_init_pkg::ST_ZQ_WAIT: begin
                if (wait_done && dll_ff == '0) begin
                    nxt_state = sdram_init_pkg::ST_READY;
                end
            end
            sdram_init_pkg::ST_READY: begin
                if (reinit) begin
                    nxt_state = sdram_init_pkg::ST_HOLD;
                    nxt_wait = CW'(RESET_HOLD_CYC - 1);
                end else if (rt_issue) begin
                    nxt_cmd = sdram_init_pkg::CMD_MRS;
                    nxt_bank = {1'b0, rt_sel_ff};
                    nxt_maddr = mr_image(rt_sel_ff, 1'b0, mr_ff[rt_sel_ff]);
                    nxt_state = sdram_init_pkg::ST_RT_GAP;
                    nxt_wait = cl_change_ff ? CW'(sdram_init_pkg::CL_GAP_CYC - 1)
                                            : CW'(sdram_init_pkg::MOD_CYC - 1);
                end
            end
            sdram_init_pkg::ST_RT_GAP: begin
                if (wait_done) begin
                    nxt_state = sdram_init_pkg::ST_READY;
                end
            end
            default: begin
                nxt_state = sdram_init_pkg::ST_HOLD;
                nxt_wait = CW'(RESET_HOLD_CYC - 1);
            end
        endcase
    end

    wire nxt_pocn = (nxt_state != sdram_init_pkg::ST_HOLD);
    // clock gate rises only after the low time and stays high through every later state until a reinit returns to ST_HOLD
    // the free-running clock has run the whole low time before the gate rises
    wire nxt_cke = nxt_pocn && (nxt_state != sdram_init_pkg::ST_CKE_WAIT);
    // termination only while ready and allowed by the control register, never during the mode-update delay in ST_RT_GAP
    wire nxt_odt = odt_allow_ff && (nxt_state == sdram_init_pkg::ST_READY);
    wire mr0_init = (state_ff == sdram_init_pkg::ST_MRS) && (init_tgt == 2'h0);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= sdram_init_pkg::ST_HOLD;
            wait_ff <= CW'(RESET_HOLD_CYC - 1);
            step_ff <= 2'h0;
            dll_ff <= '0;
            init_done_ff <= 1'b0;
            pocn_ff <= 1'b0;
            cke_ff <= 1'b0;
            odt_ff <= 1'b0;
            cmd_ff <= sdram_init_pkg::CMD_NOP;
            bank_ff <= 3'h0;
            maddr_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            step_ff <= nxt_step;
            // lock time counted from the base register write
            dll_ff <= mr0_init ? CW'(sdram_init_pkg::DLLK_CYC) : (dll_ff == '0 ? dll_ff : dll_ff - 1'b1);
            init_done_ff <= (nxt_state == sdram_init_pkg::ST_READY) || (nxt_state == sdram_init_pkg::ST_RT_GAP);
            pocn_ff <= nxt_pocn;
            cke_ff <= nxt_cke;
            odt_ff <= nxt_odt;
            cmd_ff <= nxt_cmd;
            bank_ff <= nxt_bank;
            maddr_ff <= nxt_maddr;
        end
    end

    assign power_on_clear_n = pocn_ff;
    assign clock_gate_enable = cke_ff;
    assign termination_enable = odt_ff;
    assign ddr_cmd = cmd_ff;
    assign bank_select_bits = bank_ff;
    assign mode_addr = maddr_ff;

    // helper counters watched only by the checks below
    localparam logic [CW-1:0] SAT = '1;
    logic [CW-1:0] low_cnt, cke_low_cnt, since_mrs, since_zq, since_mr0;
    wire is_mrs = (cmd_ff == sdram_init_pkg::CMD_MRS);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_cnt <= '0;
            cke_low_cnt <= '0;
            since_mrs <= SAT;
            since_zq <= '0;
            since_mr0 <= '0;
        end else begin
            low_cnt <= pocn_ff ? '0 : (low_cnt == SAT ? SAT : low_cnt + 1'b1);
            cke_low_cnt <= (!pocn_ff || cke_ff) ? '0 : (cke_low_cnt == SAT ? SAT : cke_low_cnt + 1'b1);
            since_mrs <= is_mrs ? CW'(1) : (since_mrs == SAT ? SAT : since_mrs + 1'b1);
            since_zq <= (cmd_ff == sdram_init_pkg::CMD_ZQ) ? CW'(1) : (since_zq == SAT ? SAT : since_zq + 1'b1);
            since_mr0 <= (is_mrs && bank_ff == 3'h0) ? CW'(1) : (since_mr0 == SAT ? SAT : since_mr0 + 1'b1);
        end
    end

    AST_RESET_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(power_on_clear_n) |-> low_cnt >= CW'(RESET_HOLD_CYC))
        else $error("reset released too early");
    AST_CKE_LOW_BEFORE_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(power_on_clear_n) |-> !clock_gate_enable && $past(!clock_gate_enable, 2))
        else $error("clock gate not low before reset release");
    AST_CKE_LOW_TIME: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(clock_gate_enable) |-> cke_low_cnt == CW'(CKE_LOW_CYC))
        else $error("clock gate low time wrong");
    AST_ODT_LOW_INIT: assert property (@(posedge sys_clk) disable iff (rst)
        !init_done_ff |-> !termination_enable)
        else $error("termination raised during init");
    AST_CKE_HELD: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clock_gate_enable) && power_on_clear_n |-> clock_gate_enable)
        else $error("clock gate dropped");
    AST_MR2_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
        $past(state_ff, 2) == sdram_init_pkg::ST_XPR && is_mrs |-> bank_select_bits == 3'h2)
        else $error("first mode set not to register two");
    AST_MR0_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
        is_mrs && bank_select_bits == 3'h0 |-> (mode_addr & sdram_init_pkg::MR0_RSVD_MASK) == '0)
        else $error("reserved base bits set");
    AST_INIT_DLL: assert property (@(posedge sys_clk) disable iff (rst)
        is_mrs && !init_done_ff && bank_select_bits == 3'h0 |-> mode_addr[sdram_init_pkg::MR0_DLL_RESET_BIT])
        else $error("init base write lacks dll reset");
    AST_MRS_SPACING: assert property (@(posedge sys_clk) disable iff (rst)
        is_mrs |-> $past(since_mrs) >= CW'(sdram_init_pkg::MRD_CYC))
        else $error("mode sets too close");
    AST_MOD_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        !is_mrs && ddr_cmd != sdram_init_pkg::CMD_NOP && ddr_cmd != sdram_init_pkg::CMD_DES
        |-> since_mrs >= CW'(sdram_init_pkg::MOD_CYC))
        else $error("command inside mode update delay");
    AST_ODT_MOD: assert property (@(posedge sys_clk) disable iff (rst)
        termination_enable |-> since_mrs >= CW'(sdram_init_pkg::MOD_CYC))
        else $error("termination inside mode update delay");
    AST_READY_WAITS: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(init_done_ff) |-> since_zq >= CW'(sdram_init_pkg::ZQINIT_CYC)
                                && since_mr0 >= CW'(sdram_init_pkg::DLLK_CYC))
        else $error("ready before calibration and dll lock");
endmodule : sdram_init_mode_program

// ==== sim/sdram_dev_model.sv ====
// device-side model: keeps mode registers, self-clears dll reset, times dll lock
// assumes commands are sampled on sys_clk rising edges while clock_gate_enable is high
`timescale 1ns/1ps
module sdram_dev_model (
    input wire logic sys_clk,
    input wire logic power_on_clear_n,
    input wire logic clock_gate_enable,
    input wire logic termination_enable,
    input wire sdram_init_pkg::ddr_cmd_s ddr_cmd,
    input wire logic [2:0] bank_select_bits,
    input wire logic [16:0] mode_addr,
    output logic [16:0] mr_ff [4],
    output logic dll_locked,
    output logic term_on
);
    int lock_cnt;
    logic cke_seen;
    always @(posedge sys_clk) begin
        if (!power_on_clear_n) begin
            mr_ff <= '{default: '0};
            cke_seen <= 1'b0;
            lock_cnt <= 0;
        end else if (clock_gate_enable) begin
            cke_seen <= 1'b1;
            if (lock_cnt > 0) lock_cnt <= lock_cnt - 1;
            if (ddr_cmd === sdram_init_pkg::CMD_MRS) begin
                mr_ff[bank_select_bits[1:0]] <= mode_addr;
                if (bank_select_bits[1:0] == 2'h0 && mode_addr[8]) begin
                    mr_ff[0] <= mode_addr & ~17'h0_0100;
                    lock_cnt <= 512;
                end
            end
        end
    end
    assign dll_locked = cke_seen && lock_cnt == 0;
    // outputs stay off until clock enable has been seen high
    assign term_on = cke_seen && termination_enable;
    function automatic int beats(input logic [1:0] bl, input logic a12);
        return (bl == 2'b00) ? 8 : (bl == 2'b01) ? (a12 ? 8 : 4) : (bl == 2'b10) ? 4 : 0;
    endfunction : beats
    function automatic int wrap_col(input int start, input int i, input int n);
        return (start & ~(n - 1)) | ((start + i) & (n - 1));
    endfunction : wrap_col
endmodule : sdram_dev_model

// ==== sim/tb_top.sv ====
// bench for the power-up and mode-set sequencer, with a device model on the dram pins
// assumes shortened reset and clock-enable hold counts set below
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((e) !== (a)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_top;
    localparam int unsigned RH = 20;
    localparam int unsigned CL = 30;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, banks_idle = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic hreadyout, hresp, power_on_clear_n, clock_gate_enable, termination_enable, cke_q = 0, dll_locked, term_on;
    sdram_init_pkg::ddr_cmd_s ddr_cmd;
    logic [2:0] bank_select_bits, bank2;
    logic [16:0] mode_addr, mr0_seen, mr_ff [4];
    logic [1:0] mrs_q[$];
    int n_fail = 0, checked = 0, cyc = 0, pocn_low = 0, cke_low = 0, since = 1000, cke_up = 0, first_mrs = 0;
    int mr0_cyc = 0, bad = 0;
    always #2.5 sys_clk = ~sys_clk;
    sdram_init_mode_program #(.RESET_HOLD_CYC(RH), .CKE_LOW_CYC(CL)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .banks_idle(banks_idle),
        .power_on_clear_n(power_on_clear_n), .clock_gate_enable(clock_gate_enable),
        .termination_enable(termination_enable), .ddr_cmd(ddr_cmd), .bank_select_bits(bank_select_bits),
        .mode_addr(mode_addr));
    sdram_dev_model u_dev (.sys_clk(sys_clk), .power_on_clear_n(power_on_clear_n),
        .clock_gate_enable(clock_gate_enable), .termination_enable(termination_enable), .ddr_cmd(ddr_cmd),
        .bank_select_bits(bank_select_bits), .mode_addr(mode_addr), .mr_ff(mr_ff), .dll_locked(dll_locked),
        .term_on(term_on));
    // pin monitor: sees pre-edge values, the same ones the device registers
    always @(posedge sys_clk) if (!rst) begin
        cyc++;
        since++;
        if (!power_on_clear_n) pocn_low++;
        if (power_on_clear_n && !clock_gate_enable) cke_low++;
        if (clock_gate_enable && !cke_q) begin
            cke_up = cyc;
            if (termination_enable) bad++;
        end
        if (!clock_gate_enable && cke_q && power_on_clear_n) bad++;
        cke_q = clock_gate_enable;
        if (ddr_cmd === sdram_init_pkg::CMD_MRS) begin
            if (since < sdram_init_pkg::MRD_CYC) bad++;
            if (mrs_q.size() == 0) first_mrs = cyc;
            mrs_q.push_back(bank_select_bits[1:0]);
            if (bank_select_bits[1:0] == 2'h2) bank2 = bank_select_bits;
            if (bank_select_bits == 3'h0) begin
                mr0_seen = mode_addr;
                mr0_cyc = cyc;
            end
            since = 0;
        end else if (ddr_cmd !== sdram_init_pkg::CMD_NOP && since < sdram_init_pkg::MOD_CYC) bad++;
        if (termination_enable && since < sdram_init_pkg::MOD_CYC) bad++;
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel <= 1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : bus
    task automatic wait_status(input int bit_n, input logic v);
        int n;
        n = 0;
        do begin bus(0, sdram_init_pkg::OFF_STATUS, 0); n++; end while (rd[bit_n] !== v && n < 500);
    endtask : wait_status
    task automatic test_init;
        bus(1, sdram_init_pkg::OFF_MR0, 32'h0001_2fff);
        bus(1, sdram_init_pkg::OFF_MR0 + 4, 32'h0000_0245);
        bus(1, sdram_init_pkg::OFF_MR0 + 8, 32'h0000_0018);
        bus(1, sdram_init_pkg::OFF_MR0 + 12, 32'h0000_0004);
        bus(1, sdram_init_pkg::OFF_CTRL, 32'h0000_0002);
        wait_status(sdram_init_pkg::ST_DONE_BIT, 1'b1);
        `CHK("pocn_low", 1'b1, pocn_low >= RH - 1)
        `CHK("cke_low", CL, cke_low)
        `CHK("xpr", 1'b1, first_mrs - cke_up >= sdram_init_pkg::XPR_CYC)
        `CHK("order", 8'hb4, {mrs_q[0], mrs_q[1], mrs_q[2], mrs_q[3]})
        `CHK("bank2", 3'b010, bank2)
        `CHK("mr1", 17'h0_0244, mr_ff[1])
        `CHK("mr0_img", 17'h0_0f7b, mr0_seen)
        `CHK("mr0_dev", 17'h0_0e7b, mr_ff[0])
        `CHK("mr23", 34'h0_0030_0004, {mr_ff[2], mr_ff[3]})
        `CHK("lock", 1'b1, dll_locked && cyc - mr0_cyc >= sdram_init_pkg::DLLK_CYC)
        bus(0, 8'h40, 0);
        `CHK("unmapped", 32'h0000_0000, rd)
        $display("test_init done");
    endtask : test_init
    task automatic test_runtime;
        banks_idle <= 0;
        bus(1, sdram_init_pkg::OFF_MR0 + 12, 32'h0000_0002);
        bus(1, sdram_init_pkg::OFF_MRS_REQ, 32'h0000_0003);
        repeat (20) @(posedge sys_clk);
        bus(0, sdram_init_pkg::OFF_STATUS, 0);
        `CHK("pending", 1'b1, rd[sdram_init_pkg::ST_PEND_BIT])
        `CHK("held", 17'h0_0004, mr_ff[3])
        banks_idle <= 1;
        wait_status(sdram_init_pkg::ST_PEND_BIT, 1'b0);
        wait_status(sdram_init_pkg::ST_BUSY_BIT, 1'b0);
        `CHK("mr3", 17'h0_0002, mr_ff[3])
        `CHK("odt_back", 1'b1, term_on)
        `CHK("pin_rules", 0, bad)
        $display("test_runtime done");
    endtask : test_runtime
    // reinit drops the device into reset; it must come back with the shadows replayed
    task automatic test_reinit;
        bus(1, sdram_init_pkg::OFF_CTRL, 32'h0000_0003);
        wait_status(sdram_init_pkg::ST_DONE_BIT, 1'b0);
        `CHK("reinit_pocn", 1'b0, power_on_clear_n)
        wait_status(sdram_init_pkg::ST_DONE_BIT, 1'b1);
        `CHK("reinit_mr3", 17'h0_0002, mr_ff[3])
        `CHK("reinit_mr0", 17'h0_0e7b, mr_ff[0])
        `CHK("reinit_pins", 0, bad)
        $display("test_reinit done");
    endtask : test_reinit
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        test_init;
        test_runtime;
        test_reinit;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test;
    end
endmodule : tb_top
